/* rtl/cff_pkg.sv */
// shared constants for the can filter and queue event block
package cff_pkg;
    localparam int NQ = 32;
    localparam int NF = 32;
    localparam int NMASK = 4;
    localparam int QDEPTH = 32;
    localparam int QIDX_W = 5;
    localparam int LVL_W = 6;
    localparam int ID_W = 29;
    localparam int STD_W = 11;
    localparam int NFLAG = 7;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_QSEL = 8'h04;
    localparam logic [7:0] A_QINT = 8'h08;
    localparam logic [7:0] A_QCFG = 8'h0C;
    localparam logic [7:0] A_CMD = 8'h10;
    localparam logic [3:0] A_MASK_HI = 4'h2;
    localparam logic [2:0] A_FCTL_HI = 3'h2;
    localparam logic [3:0] A_PAGE = 4'h0;
    // control word fields
    localparam int CT_LOOP = 0;
    localparam int CT_ALL = 1;
    localparam int CT_LISTEN = 2;
    localparam int CT_CATCH = 8;
    localparam int CT_DIV = 16;
    localparam logic [31:0] CTRL_WMASK = 32'hFFFF_1F07;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // filter byte fields
    localparam int FB_EN = 7;
    localparam int FB_MS = 5;
    localparam logic [7:0] FCTL_RST = 8'h00;
    // queue config and command fields
    localparam int QC_TX = 7;
    localparam int QC_PRIO = 0;
    localparam int CMD_LOAD = 8;
    localparam int CMD_REL = 9;
    // queue event register fields
    localparam int IE_TX = 24;
    localparam int IE_RX = 16;
    localparam int FL_TX = 8;
    localparam int FL_RX_OVR = 3;
    localparam logic [6:0] IE_RST = 7'h00;
    // bit rate ceiling
    localparam int CLK_HZ = 100_000_000;
    localparam int MAX_BPS = 1_000_000;
    localparam logic [15:0] MIN_BIT_CYC = 16'((CLK_HZ + MAX_BPS - 1) / MAX_BPS);
endpackage

/* rtl/cff_queue_if.sv */
// bookkeeping signals between the top and one message queue
interface cff_queue_if;
    import cff_pkg::*;
    logic push;
    logic pop;
    logic isTx;
    logic clrOvr;
    logic [LVL_W-1:0] level;
    logic [NFLAG-1:0] flags;
    modport ctl (output push, output pop, output isTx, output clrOvr,
        input level, input flags);
    modport que (input push, input pop, input isTx, input clrOvr,
        output level, output flags);
endinterface

/* rtl/cff_filter_match.sv */
// one acceptance filter compare
module cff_filter_match (
    input wire logic filterOn,
    input wire logic [cff_pkg::ID_W:0] filterId,
    input wire logic [cff_pkg::ID_W-1:0] maskBits,
    input wire logic [cff_pkg::ID_W-1:0] msgId,
    input wire logic msgExt,
    output logic hit
);
    import cff_pkg::*;
    logic [ID_W-1:0] care;
    always_comb begin
        // standard frames only compare the low identifier bits
        care = msgExt ? maskBits
            : {{(ID_W-STD_W){1'b0}}, maskBits[STD_W-1:0]};
        hit = filterOn && (filterId[ID_W] == msgExt)
            && (((filterId[ID_W-1:0] ^ msgId) & care) == '0);
    end
endmodule // cff_filter_match

/* rtl/cff_queue_status.sv */
// occupancy and status flags of one message queue
module cff_queue_status (
    input wire logic sys_clk,
    input wire logic reset,
    cff_queue_if.que q
);
    import cff_pkg::*;
    logic [LVL_W-1:0] level_q;
    logic ovr_q;
    logic full;
    logic empty;
    logic half;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    assign full = level_q == LVL_W'(QDEPTH);
    assign empty = level_q == '0;
    assign half = level_q >= LVL_W'(QDEPTH / 2);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_q <= '0;
        end else if (q.push && !full && !(q.pop && !empty)) begin
            level_q <= level_q + 1'b1;
        end else if (q.pop && !empty && !(q.push && !full)) begin
            level_q <= level_q - 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ovr_q <= 1'b0;
        end else if (q.push && full && !q.isTx) begin
            ovr_q <= 1'b1;
        end else if (q.clrOvr) begin
            ovr_q <= 1'b0;
        end
    end
    assign q.level = level_q;
    // flags follow the live level; only the sticky overflow is cleared by a write
    assign q.flags = {q.isTx && !full, q.isTx && half, q.isTx && empty,
        ovr_q, !q.isTx && full, !q.isTx && half,
        !q.isTx && !empty};

    a_ovr_sets: assert property (
        q.push && full && !q.isTx |=> ovr_q)
        else $error("overflow flag missed a dropped message");
    a_ovr_sticky: assert property (
        ovr_q && !q.clrOvr |=> ovr_q)
        else $error("overflow flag cleared without software");
    a_rx_no_space: assert property (
        !q.isTx |-> !q.flags[6])
        else $error("receive queue shows transmit space");
endmodule // cff_queue_status

/* rtl/cff_can_filter_fifo_irq.sv */
// can acceptance filters, message queue bookkeeping and event logic
// Contract
// - accept standard and extended identifiers
// - bit rate programmable, at most 1 Mbps
// - 32 queues of 32 messages each
// - each queue either transmit or receive
// - transmit queues arbitrated by software priority
// - 32 independent acceptance filters
// - 2-bit code picks one of four masks
// - filter takes part only when enabled
// - 5-bit selector names the target queue
// - control word packs four filters, one per byte
// - mask and target locked while enabled
// - transmit enables at bits 26 to 24
// - space flag only in transmit queues
// - status flags read-only, track live level; the overflow flag is sticky and is cleared by a queue event write
// - unused event bits read zero
// - matching remote request triggers automatic reply
// - loopback, accept-all and listen-only modes
// - message store requested from dedicated channel
//
// The APB slave port and the register addresses were decided locally.
module cff_can_filter_fifo_irq (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxValid,
    input wire logic [cff_pkg::ID_W-1:0] rxId,
    input wire logic rxExt,
    input wire logic rxRtr,
    input wire logic txDone,
    output logic txValid,
    output logic [cff_pkg::QIDX_W-1:0] txQueue,
    output logic autoReplyStb,
    output logic [cff_pkg::QIDX_W-1:0] autoReplyQueue,
    output logic dmaStoreStb,
    output logic [cff_pkg::QIDX_W-1:0] dmaStoreQueue,
    output logic bitTick,
    output logic modeLoopback,
    output logic modeListenOnly,
    output logic irq
);
    import cff_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [31:0] ctrl_q;
    logic [QIDX_W-1:0] qsel_q;
    logic [7:0] fctl_q [NF];
    logic [ID_W:0] fid_q [NF];
    logic [ID_W-1:0] mask_q [NMASK];
    logic [NQ-1:0] isTx_q;
    logic [1:0] prio_q [NQ];
    logic [NFLAG-1:0] ie_q [NQ];
    logic [15:0] bitCnt_q;
    logic [NF-1:0] hit;
    logic [NFLAG-1:0] flags [NQ];
    logic [LVL_W-1:0] level [NQ];
    logic [NQ-1:0] qReq;
    logic [31:0] rdData;
    logic [31:0] qintRd;
    logic rdErr;
    logic setup;
    logic wrOk;
    logic [7:0] addr;
    logic hitAny;
    logic [QIDX_W-1:0] hitIdx;
    logic [QIDX_W-1:0] target;
    logic accept;
    logic rxStore;
    logic rtrHit;
    logic cmdLoad;
    logic cmdRel;
    logic [QIDX_W-1:0] cmdQ;
    logic qintClr;
    logic arbValid;
    logic [QIDX_W-1:0] arbIdx;
    logic [1:0] arbPrio;
    logic [15:0] bitDiv;

    cff_queue_if qi [NQ] ();

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b+:8] = nw[8*b+:8];
            end
        end
        return r;
    endfunction

    // bus side: no wait state; read data is registered in the setup cycle so it comes from a flop
    assign addr = paddr[7:0];
    assign setup = psel && !penable;
    assign wrOk = psel && penable && pready && pwrite && !rdErr;
    assign cmdLoad = wrOk && addr == A_CMD && pwdata[CMD_LOAD];
    assign cmdRel = wrOk && addr == A_CMD && pwdata[CMD_REL];
    assign cmdQ = pwdata[QIDX_W-1:0];
    assign qintClr = wrOk && addr == A_QINT && pstrb[0]
        && !pwdata[FL_RX_OVR];

    assign qintRd = {5'h0, ie_q[qsel_q][6:4], 4'h0, ie_q[qsel_q][3:0],
        5'h0, flags[qsel_q][6:4], 4'h0,
        flags[qsel_q][3:0]};

    always_comb begin
        rdData = '0;
        rdErr = 1'b0;
        if (paddr[11:8] != A_PAGE || paddr[1:0] != 2'b00) begin
            rdErr = 1'b1;
        end else if (addr == A_CTRL) begin
            rdData = ctrl_q;
        end else if (addr == A_QSEL) begin
            rdData = 32'(qsel_q);
        end else if (addr == A_QINT) begin
            rdData = qintRd;
        end else if (addr == A_QCFG) begin
            rdData = 32'({isTx_q[qsel_q], 5'h0, prio_q[qsel_q]});
        end else if (addr == A_CMD) begin
            rdData = '0;
        end else if (addr[7:4] == A_MASK_HI) begin
            rdData = 32'(mask_q[addr[3:2]]);
        end else if (addr[7:5] == A_FCTL_HI) begin
            rdData = {fctl_q[{addr[4:2], 2'd3}], fctl_q[{addr[4:2], 2'd2}],
                fctl_q[{addr[4:2], 2'd1}],
                fctl_q[{addr[4:2], 2'd0}]};
        end else if (addr[7]) begin
            rdData = 32'(fid_q[addr[6:2]]);
        end else begin
            rdErr = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && rdErr;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RST;
            qsel_q <= '0;
        end else if (wrOk && addr == A_CTRL) begin
            ctrl_q <= merge(ctrl_q, pwdata, pstrb) & CTRL_WMASK;
        end else if (wrOk && addr == A_QSEL && pstrb[0]) begin
            qsel_q <= pwdata[QIDX_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int n = 0; n < NF; n++) begin
                fctl_q[n] <= FCTL_RST;
            end
        end else if (wrOk && addr[7:5] == A_FCTL_HI) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    fctl_q[{addr[4:2], 2'(b)}][FB_EN] <= pwdata[8*b+FB_EN];
                    // fields are frozen while the filter is live
                    if (!fctl_q[{addr[4:2], 2'(b)}][FB_EN]) begin
                        fctl_q[{addr[4:2], 2'(b)}][FB_EN-1:0] <=
                            pwdata[8*b+:FB_EN];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int n = 0; n < NF; n++) begin
                fid_q[n] <= '0;
            end
            for (int m = 0; m < NMASK; m++) begin
                mask_q[m] <= '0;
            end
        end else if (wrOk && addr[7]) begin
            fid_q[addr[6:2]] <= (ID_W+1)'(merge(32'(fid_q[addr[6:2]]),
                pwdata, pstrb));
        end else if (wrOk && addr[7:4] == A_MASK_HI) begin
            mask_q[addr[3:2]] <= ID_W'(merge(32'(mask_q[addr[3:2]]),
                pwdata, pstrb));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            isTx_q <= '0;
            for (int n = 0; n < NQ; n++) begin
                prio_q[n] <= 2'h0;
                ie_q[n] <= IE_RST;
            end
        end else begin
            if (wrOk && addr == A_QCFG && pstrb[0]) begin
                isTx_q[qsel_q] <= pwdata[QC_TX];
                prio_q[qsel_q] <= pwdata[QC_PRIO+:2];
            end
            if (wrOk && addr == A_QINT && pstrb[3]) begin
                ie_q[qsel_q][6:4] <= pwdata[IE_TX+:3];
            end
            if (wrOk && addr == A_QINT && pstrb[2]) begin
                ie_q[qsel_q][3:0] <= pwdata[IE_RX+:4];
            end
        end
    end

    // acceptance: lowest numbered hit wins
    for (genvar f = 0; f < NF; f++) begin : gFilt
        cff_filter_match uFilt (
            .filterOn(fctl_q[f][FB_EN]),
            .filterId(fid_q[f]),
            .maskBits(mask_q[fctl_q[f][FB_MS+:2]]),
            .msgId(rxId),
            .msgExt(rxExt),
            .hit(hit[f])
        );
    end

    always_comb begin
        hitAny = 1'b0;
        hitIdx = '0;
        for (int n = NF - 1; n >= 0; n--) begin
            if (hit[n]) begin
                hitAny = 1'b1;
                hitIdx = QIDX_W'(n);
            end
        end
    end

    assign target = hitAny ? fctl_q[hitIdx][QIDX_W-1:0]
        : ctrl_q[CT_CATCH+:QIDX_W];
    assign accept = rxValid && (hitAny || ctrl_q[CT_ALL]);
    assign rxStore = accept && !isTx_q[target];
    assign rtrHit = accept && rxRtr && isTx_q[target]
        && !ctrl_q[CT_LISTEN];

    for (genvar g = 0; g < NQ; g++) begin : gQue
        assign qi[g].push = (rxStore && target == QIDX_W'(g))
            || (cmdLoad && cmdQ == QIDX_W'(g) && isTx_q[g]);
        assign qi[g].pop = (cmdRel && cmdQ == QIDX_W'(g) && !isTx_q[g])
            || (txDone && txValid && txQueue == QIDX_W'(g));
        assign qi[g].isTx = isTx_q[g];
        assign qi[g].clrOvr = qintClr && qsel_q == QIDX_W'(g);
        assign flags[g] = qi[g].flags;
        assign level[g] = qi[g].level;
        assign qReq[g] = |(flags[g] & ie_q[g]);
        cff_queue_status uQue (
            .sys_clk(sys_clk),
            .reset(reset),
            .q(qi[g])
        );
    end

    // highest priority wins, ties go to the lowest queue
    always_comb begin
        arbValid = 1'b0;
        arbIdx = '0;
        arbPrio = 2'h0;
        for (int n = 0; n < NQ; n++) begin
            if (isTx_q[n] && level[n] != '0
                && (!arbValid || prio_q[n] > arbPrio)) begin
                arbValid = 1'b1;
                arbIdx = QIDX_W'(n);
                arbPrio = prio_q[n];
            end
        end
    end

    // queue is held until the engine reports the frame done or listen-only is set
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txValid <= 1'b0;
            txQueue <= '0;
        end else if (txDone || ctrl_q[CT_LISTEN]) begin
            txValid <= 1'b0;
        end else if (!txValid) begin
            txValid <= arbValid;
            txQueue <= arbIdx;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            autoReplyStb <= 1'b0;
            autoReplyQueue <= '0;
        end else begin
            autoReplyStb <= rtrHit;
            if (rtrHit) begin
                autoReplyQueue <= target;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dmaStoreStb <= 1'b0;
            dmaStoreQueue <= '0;
        end else begin
            dmaStoreStb <= rxStore
                && level[target] != LVL_W'(QDEPTH);
            if (rxStore) begin
                dmaStoreQueue <= target;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            modeLoopback <= 1'b0;
            modeListenOnly <= 1'b0;
            irq <= 1'b0;
        end else begin
            modeLoopback <= ctrl_q[CT_LOOP];
            modeListenOnly <= ctrl_q[CT_LISTEN];
            irq <= |qReq;
        end
    end

    // a divisor below the floor is raised so the rate stays legal
    assign bitDiv = (ctrl_q[CT_DIV+:16] < MIN_BIT_CYC) ? MIN_BIT_CYC
        : ctrl_q[CT_DIV+:16];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bitCnt_q <= '0;
            bitTick <= 1'b0;
        end else if (bitCnt_q >= bitDiv - 16'd1) begin
            bitCnt_q <= '0;
            bitTick <= 1'b1;
        end else begin
            bitCnt_q <= bitCnt_q + 16'd1;
            bitTick <= 1'b0;
        end
    end

    sequence sRemote;
        rxValid && rxRtr && hitAny && isTx_q[target] && !ctrl_q[CT_LISTEN];
    endsequence
    sequence sReply(logic [QIDX_W-1:0] q);
        autoReplyStb && autoReplyQueue == q;
    endsequence

    a_auto_reply: assert property (
        sRemote |=> sReply($past(target)))
        else $error("no automatic reply to remote request");
    a_filter_lock: assert property (
        fctl_q[16][FB_EN] |=> fctl_q[16][6:0] == $past(fctl_q[16][6:0]))
        else $error("enabled filter fields changed");
    a_irq_follows: assert property (
        ##1 irq == ($past(qReq) != '0))
        else $error("interrupt does not follow enabled flags");
    a_tick_spacing: assert property (
        bitTick |=> !bitTick [*8])
        else $error("bit tick faster than allowed");
    a_listen_quiet: assert property (
        ctrl_q[CT_LISTEN] |=> !txValid && !autoReplyStb)
        else $error("listen-only mode requested a transmission");
    a_tx_is_tx: assert property (
        txValid && !$past(txValid) |-> isTx_q[txQueue]
            && prio_q[txQueue] == $past(arbPrio))
        else $error("transmit picked wrong queue");
    a_level_cap: assert property (
        level[qsel_q] <= LVL_W'(QDEPTH))
        else $error("queue level above depth");
    a_store_req: assert property (
        rxStore && level[target] == '0 |=> dmaStoreStb)
        else $error("accepted message not stored");
endmodule // cff_can_filter_fifo_irq

/* bench/cff_can_node_model.sv */
// far-side can node model: presents frames and finishes transmissions
module cff_can_node_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic txValid,
    output logic rxValid,
    output logic [cff_pkg::ID_W-1:0] rxId,
    output logic rxExt,
    output logic rxRtr,
    output logic txDone
);
    timeunit 1ns;
    timeprecision 1ps;
    import cff_pkg::*;
    int respDelay = 5;
    int waitCnt = 0;
    initial begin
        rxValid = 1'b0;
        rxId = '0;
        rxExt = 1'b0;
        rxRtr = 1'b0;
        txDone = 1'b0;
    end
    // called just after a rising edge; returns just after one
    task automatic send(input logic [ID_W-1:0] id, input logic ext,
        input logic rtr);
        rxValid <= 1'b1;
        rxId <= id;
        rxExt <= ext;
        rxRtr <= rtr;
        @(posedge sys_clk);
        rxValid <= 1'b0;
        // idle lines show the inverse so no stale id looks valid
        rxId <= ~id;
        rxExt <= ~ext;
        rxRtr <= ~rtr;
        @(posedge sys_clk);
    endtask
    // slow answer on purpose; counter restarts if the offer is withdrawn
    always @(posedge sys_clk) begin
        if (reset || txDone || !txValid) begin
            txDone <= 1'b0;
            waitCnt <= 0;
        end else if (waitCnt == respDelay) begin
            txDone <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule // cff_can_node_model

/* bench/tb_top.sv */
// register-level testbench for the can filter and queue event block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cff_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr;
    logic rxValid, rxExt, rxRtr, txDone, txValid;
    logic [ID_W-1:0] rxId;
    logic [QIDX_W-1:0] txQueue, autoReplyQueue, dmaStoreQueue;
    logic autoReplyStb, dmaStoreStb, bitTick, irq;
    logic modeLoopback, modeListenOnly;
    logic [4:0] storeQ, replyQ;
    logic [4:0] txLog [4];
    int fail_count = 0;
    int checks_done = 0;
    int storeCnt = 0, replyCnt = 0, txCnt = 0, gap = 0, lastGap = 0;
    int ticks = 0;
    int n, t0;

    cff_can_filter_fifo_irq dut_u (.sys_clk(sys_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxValid(rxValid), .rxId(rxId), .rxExt(rxExt),
        .rxRtr(rxRtr), .txDone(txDone), .txValid(txValid),
        .txQueue(txQueue), .autoReplyStb(autoReplyStb),
        .autoReplyQueue(autoReplyQueue), .dmaStoreStb(dmaStoreStb),
        .dmaStoreQueue(dmaStoreQueue), .bitTick(bitTick),
        .modeLoopback(modeLoopback), .modeListenOnly(modeListenOnly),
        .irq(irq));
    cff_can_node_model node_u (.sys_clk(sys_clk), .reset(reset),
        .txValid(txValid), .rxValid(rxValid), .rxId(rxId), .rxExt(rxExt),
        .rxRtr(rxRtr), .txDone(txDone));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // event monitors; read only several edges after the event
    always @(posedge sys_clk) begin
        if (dmaStoreStb === 1'b1) begin
            storeCnt++;
            storeQ = dmaStoreQueue;
        end
        if (autoReplyStb === 1'b1) begin
            replyCnt++;
            replyQ = autoReplyQueue;
        end
        if (txDone === 1'b1 && txValid === 1'b1 && txCnt < 4) begin
            txLog[txCnt] = txQueue;
            txCnt++;
        end
        if (bitTick === 1'b1) begin
            lastGap = gap;
            gap = 1;
            ticks++;
        end else begin
            gap++;
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            $display("[ERR] %0t bus answer missing", $time);
            results();
        end else begin
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // one idle edge so the next setup never overwrites the release
            @(posedge sys_clk);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a);
        xfer(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(12'h050);
        check(rdata, 32'h0000_0000);
        wr(12'h004, 32'h0000_0000);
        rd(12'h008);
        check(rdata & 32'hFFFF_FCFF, 32'h0000_0000);
        wr(12'h008, 32'hFFFF_FFFF);
        rd(12'h008);
        check(rdata & 32'hFFFF_FCFF, 32'h070F_0000);
        wr(12'h008, 32'h0000_0000);
        rd(12'h100);
        check(rerr, 1'b1);
        check(rdata, 32'h0000_0000);
        // filter 19 fields lock while its enable is set
        wr(12'h050, 32'hE500_0000);
        rd(12'h050);
        check(rdata, 32'hE500_0000);
        wr(12'h050, 32'h9F00_0000);
        rd(12'h050);
        check(rdata, 32'hE500_0000);
        wr(12'h050, 32'h1F00_0000);
        rd(12'h050);
        check(rdata, 32'h6500_0000);
        wr(12'h050, 32'h1F00_0000);
        rd(12'h050);
        check(rdata, 32'h1F00_0000);
        // filter 16: extended id, full compare mask, into queue 2
        wr(12'h020, 32'h1FFF_FFFF);
        wr(12'h0C0, 32'h2123_4567);
        wr(12'h050, 32'h1F00_0082);
        wr(12'h004, 32'h0000_0002);
        wr(12'h008, 32'h0001_0000);
        for (n = 0; n < 33; n++) node_u.send(29'h123_4567, 1'b1, 1'b0);
        idle(3);
        check(storeCnt, 32);
        check(storeQ, 5'd2);
        rd(12'h008);
        check(rdata & 32'h000F_000F, 32'h0001_000F);
        check(irq, 1'b1);
        wr(12'h008, 32'h0001_0000);
        rd(12'h008);
        check(rdata[3:0], 4'h7);
        wr(12'h010, 32'h0000_0202);
        rd(12'h008);
        check(rdata[3:0], 4'h3);
        wr(12'h008, 32'h0000_0000);
        idle(3);
        check(irq, 1'b0);
        node_u.send(29'h123_4567, 1'b0, 1'b0);
        node_u.send(29'h000_0000, 1'b0, 1'b0);
        idle(3);
        check(storeCnt, 32);
        // accept-all into queue 3, loopback flag copied out
        wr(12'h000, 32'h0000_0303);
        node_u.send(29'h000_0007, 1'b0, 1'b0);
        idle(3);
        check(storeCnt, 33);
        check(storeQ, 5'd3);
        check(modeLoopback, 1'b1);
        wr(12'h000, 32'h0000_0000);
        // remote request through filter 17 (mask 1 open) to queue 5
        wr(12'h004, 32'h0000_0005);
        wr(12'h00C, 32'h0000_0081);
        wr(12'h050, 32'h1F00_A582);
        node_u.send(29'h000_0055, 1'b0, 1'b1);
        idle(3);
        check(replyCnt, 1);
        check(replyQ, 5'd5);
        // load two transmit queues while listen-only holds the offer off
        wr(12'h000, 32'h0000_0004);
        wr(12'h004, 32'h0000_0006);
        wr(12'h00C, 32'h0000_0083);
        wr(12'h010, 32'h0000_0105);
        wr(12'h010, 32'h0000_0106);
        idle(2);
        check(txValid, 1'b0);
        check(modeListenOnly, 1'b1);
        wr(12'h004, 32'h0000_0005);
        rd(12'h008);
        check(rdata[10], 1'b1);
        wr(12'h000, 32'h0000_0000);
        for (n = 0; n < 400 && txCnt < 2; n++) @(posedge sys_clk);
        check(txCnt, 2);
        check(txLog[0], 5'd6);
        check(txLog[1], 5'd5);
        for (n = 0; n < 1000 && ticks < 3; n++) @(posedge sys_clk);
        check(lastGap >= int'(MIN_BIT_CYC), 1'b1);
        // programmed divisor sets the gap; one below the floor is raised
        wr(12'h000, 32'h00C8_0000);
        t0 = ticks;
        for (n = 0; n < 1000 && ticks < t0 + 3; n++) @(posedge sys_clk);
        check(lastGap, 200);
        wr(12'h000, 32'h0005_0000);
        t0 = ticks;
        for (n = 0; n < 1000 && ticks < t0 + 3; n++) @(posedge sys_clk);
        check(lastGap, int'(MIN_BIT_CYC));
        results();
    end
endmodule // tb_top
